// *** verilog/eec_pkg.sv ***
/*
 * Shared constants and types for the two-wire EEPROM client front end.
 * Assumes a 25 MHz core clock and an open-drain serial data wire outside.
 */
package eec_pkg;
	localparam int CLK_PERIOD_NS = 40;
	// spike suppression window on both serial inputs
	localparam int SPIKE_NS = 50;
	localparam int FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_W = 3;
	// self-timed write cycle, longest time
	localparam int WRITE_MS = 5;
	localparam int WRITE_CYC = (WRITE_MS * 1000000) / CLK_PERIOD_NS;
	localparam int WCNT_W = 17;

	localparam int MEM_BYTES = 256;
	localparam int PAGE_BYTES = 16;
	localparam int PTR_W = 8;
	localparam int IDX_W = 4;

	// control byte field positions
	localparam int CODE_MSB = 7;
	localparam int CODE_LSB = 4;
	localparam int CS_MSB = 3;
	localparam int CS_LSB = 1;
	localparam int RW_BIT = 0;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;
	localparam logic [7:0] SHIFT_RESET = 8'hff;
	localparam logic [7:0] PTR_RESET = 8'h00;

	typedef struct packed {
		logic scl;
		logic sda;
	} eec_line_s;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_CTRL = 7'h02,
		ST_ADDR = 7'h04,
		ST_WDATA = 7'h08,
		ST_ACK = 7'h10,
		ST_TX = 7'h20,
		ST_TXACK = 7'h40
	} eec_state_e;
endpackage

// *** verilog/eec_line_filter.sv ***
/*
 * Two-flop synchroniser and spike filter for the serial clock and data pins.
 * Assumes raw pin levels asynchronous to the core clock; idle level is high.
 */
module eec_line_filter
	import eec_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input eec_pkg::eec_line_s raw_in,
	output eec_pkg::eec_line_s clean_out
);
	logic [1:0] raw_bits;
	logic [1:0] clean_bits;

	assign raw_bits = raw_in;
	assign clean_out = clean_bits;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_line
			logic meta_q;
			logic sync_q;
			logic out_q;
			logic [FILT_W-1:0] cnt_q;

			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
				end else begin
					meta_q <= raw_bits[g];
					sync_q <= meta_q;
				end
			end

			// a new level must hold for the whole window before it is passed on
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					cnt_q <= '0;
					out_q <= 1'b1;
				end else if (sync_q == out_q) begin
					cnt_q <= '0;
				end else if (cnt_q == FILT_W'(FILT_CYC - 1)) begin
					cnt_q <= '0;
					out_q <= sync_q;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end

			assign clean_bits[g] = out_q;
		end
	endgenerate
endmodule

// *** verilog/eec_client.sv ***
/*
 * Two-wire serial client of a 256-byte EEPROM: bus conditions, control byte
 * match, word address, 16-byte page buffer, self-timed write and reads.
 * Assumes an external host drives the serial clock and a pull-up on data.
 */
// Summary of operation
// - respond only when all three strapped chip-select pins match the control byte
// - data changes only with clock low; changes with clock high are conditions
// - data falling while clock high is a Start
// - data rising while clock high is a Stop
// - one bit per clock pulse, sampled while clock is high
// - write keeps only the latest 16 bytes, oldest overwritten first
// - receiver acknowledges each byte on a ninth clock pulse
// - no acknowledge at all while the programming cycle runs
// - acknowledger holds data low through the acknowledge clock high phase
// - host not acknowledging ends a read; device releases data line
// - first byte after Start is control byte; 4-bit type code must match
// - next three control bits are chip selects, highest pin first
// - control byte bit zero: one reads, zero writes
// - byte after a write control byte is the word address
// - matching address is acknowledged, then read or write follows
// - sequential reads never carry into another device
// - low supply report blocks internal erase and write
// - write-protect high blocks array writes; low allows them
// - write cycle begun by Stop completes within 5 ms, no acknowledges
// - address pointer advances by one per access; reads wrap from the top address to zero
// - page write increments only low four pointer bits
module eec_client
	import eec_pkg::*;
#(
	// arbitrary device-type code value
	parameter logic [3:0] DEVICE_CODE = 4'h5,
	parameter int WRITE_CYCLES = WRITE_CYC
)
(
	input wire logic CORE_CLK_IN,
	input wire logic RESET_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	input wire logic CHIP_SELECT_PIN_LOW_IN,
	input wire logic CHIP_SELECT_PIN_MID_IN,
	input wire logic CHIP_SELECT_PIN_HIGH_IN,
	input wire logic WRITE_PROTECT_IN,
	input wire logic SUPPLY_LOW_IN,
	output logic WRITE_BUSY_OUT
);
	import eec_pkg::*;

	function automatic logic is_rx(input eec_state_e st);
		is_rx = (st == ST_CTRL) || (st == ST_ADDR) || (st == ST_WDATA);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// input conditioning

	eec_line_s raw_line;
	eec_line_s line;
	logic scl_q;
	logic sda_q;
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	logic [2:0] cs_pins;
	logic wp_on;
	logic supply_low;

	assign raw_line = '{scl: SCL_IN, sda: SDA_IN};

	eec_line_filter u_filter (
		.clk_in(CORE_CLK_IN),
		.rst_in(RESET_IN),
		.raw_in(raw_line),
		.clean_out(line)
	);

	// strap and level pins are slow but still asynchronous
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			pin_meta_q <= 5'h00;
			pin_sync_q <= 5'h00;
		end else begin
			pin_meta_q <= {SUPPLY_LOW_IN, WRITE_PROTECT_IN, CHIP_SELECT_PIN_HIGH_IN,
				CHIP_SELECT_PIN_MID_IN, CHIP_SELECT_PIN_LOW_IN};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign cs_pins = pin_sync_q[2:0];
	assign wp_on = pin_sync_q[3];
	assign supply_low = pin_sync_q[4];

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= line.scl;
			sda_q <= line.sda;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	assign scl_rise = line.scl && !scl_q;
	assign scl_fall = !line.scl && scl_q;
	// data moving during clock high is a condition, never a bit
	assign start_seen = line.scl && scl_q && sda_q && !line.sda;
	assign stop_seen = line.scl && scl_q && !sda_q && line.sda;

	////////////////////////////////////////////////////////////////////////
	// protocol state

	eec_state_e state_q;
	eec_state_e after_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic ack_q;
	logic host_ack_q;
	logic wr_active_q;
	logic [PTR_W-1:0] ptr_q;
	logic busy_q;
	logic byte_done;
	logic ctrl_match;

	logic [7:0] mem [MEM_BYTES];
	logic [7:0] page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] valid_q;

	assign byte_done = is_rx(state_q) && scl_fall && (bit_cnt_q == BITS_PER_BYTE);
	assign ctrl_match = (shift_q[CODE_MSB:CODE_LSB] == DEVICE_CODE)
		&& (shift_q[CS_MSB:CS_LSB] == cs_pins);

	// a condition anywhere aborts the byte in flight
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state_q <= ST_IDLE;
		end else if (start_seen) begin
			state_q <= ST_CTRL;
		end else if (stop_seen) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: state_q <= ST_IDLE;
				ST_CTRL, ST_ADDR, ST_WDATA: begin
					if (byte_done)
						state_q <= ST_ACK;
				end
				ST_ACK: begin
					if (scl_fall)
						state_q <= ack_q ? after_q : ST_IDLE;
				end
				ST_TX: begin
					if (scl_fall && bit_cnt_q == LAST_TX_BIT)
						state_q <= ST_TXACK;
				end
				ST_TXACK: begin
					if (scl_fall)
						state_q <= host_ack_q ? ST_TX : ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			bit_cnt_q <= 4'h0;
		end else if (start_seen || stop_seen) begin
			bit_cnt_q <= 4'h0;
		end else if (is_rx(state_q)) begin
			if (byte_done)
				bit_cnt_q <= 4'h0;
			else if (scl_rise)
				bit_cnt_q <= bit_cnt_q + 4'h1;
		end else if (state_q == ST_TX) begin
			if (scl_fall)
				bit_cnt_q <= (bit_cnt_q == LAST_TX_BIT) ? 4'h0 : bit_cnt_q + 4'h1;
		end else begin
			bit_cnt_q <= 4'h0;
		end
	end

	// acknowledge decision taken when a received byte completes
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			ack_q <= 1'b0;
			after_q <= ST_IDLE;
		end else if (byte_done) begin
			case (state_q)
				ST_CTRL: begin
					ack_q <= ctrl_match && !busy_q;
					after_q <= shift_q[RW_BIT] ? ST_TX : ST_ADDR;
				end
				ST_ADDR: begin
					ack_q <= 1'b1;
					after_q <= ST_WDATA;
				end
				default: begin
					ack_q <= 1'b1;
					after_q <= ST_WDATA;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			host_ack_q <= 1'b0;
		else if (state_q == ST_TXACK && scl_rise)
			host_ack_q <= !line.sda;
	end

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			shift_q <= SHIFT_RESET;
		end else if (is_rx(state_q) && scl_rise) begin
			shift_q <= {shift_q[6:0], line.sda};
		end else if (state_q == ST_ACK && scl_fall && ack_q && after_q == ST_TX) begin
			shift_q <= mem[ptr_q];
		end else if (state_q == ST_TXACK && scl_fall && host_ack_q) begin
			shift_q <= mem[ptr_q];
		end else if (state_q == ST_TX && scl_fall) begin
			shift_q <= {shift_q[6:0], 1'b1};
		end
	end

	// pointer covers only this device, so reads wrap instead of carrying
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			ptr_q <= PTR_RESET;
		end else if (byte_done && state_q == ST_ADDR) begin
			ptr_q <= shift_q;
		end else if (byte_done && state_q == ST_WDATA) begin
			ptr_q[IDX_W-1:0] <= ptr_q[IDX_W-1:0] + 4'h1;
		end else if (state_q == ST_ACK && scl_fall && ack_q && after_q == ST_TX) begin
			ptr_q <= ptr_q + 8'h01;
		end else if (state_q == ST_TXACK && scl_fall && host_ack_q) begin
			ptr_q <= ptr_q + 8'h01;
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			wr_active_q <= 1'b0;
		else if (start_seen || stop_seen)
			wr_active_q <= 1'b0;
		else if (byte_done && state_q == ST_ADDR)
			wr_active_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// page buffer and self-timed write

	logic commit_go;
	logic [WCNT_W-1:0] wcnt_q;
	logic [IDX_W:0] commit_idx_q;
	logic commit_en;

	// an address-only write (random read set-up) starts no cycle
	assign commit_go = stop_seen && wr_active_q && (|valid_q) && !busy_q;
	assign commit_en = busy_q && !commit_idx_q[IDX_W];

	// same slot reused on wrap: the newest byte replaces the oldest
	always_ff @(posedge CORE_CLK_IN) begin
		if (byte_done && state_q == ST_WDATA)
			page_buf[ptr_q[IDX_W-1:0]] <= shift_q;
	end

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			valid_q <= '0;
		else if (byte_done && state_q == ST_ADDR)
			valid_q <= '0;
		else if (byte_done && state_q == ST_WDATA)
			valid_q[ptr_q[IDX_W-1:0]] <= 1'b1;
		else if (busy_q && wcnt_q == '0)
			valid_q <= '0;
	end

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			busy_q <= 1'b0;
			wcnt_q <= '0;
		end else if (commit_go) begin
			busy_q <= 1'b1;
			wcnt_q <= WCNT_W'(WRITE_CYCLES - 1);
		end else if (busy_q) begin
			if (wcnt_q == '0)
				busy_q <= 1'b0;
			else
				wcnt_q <= wcnt_q - 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			commit_idx_q <= '0;
		else if (commit_go)
			commit_idx_q <= '0;
		else if (commit_en)
			commit_idx_q <= commit_idx_q + 1'b1;
	end

	// protected or low-supply writes still run the full timed cycle
	always_ff @(posedge CORE_CLK_IN) begin
		if (commit_en && valid_q[commit_idx_q[IDX_W-1:0]] && !wp_on && !supply_low)
			mem[{ptr_q[PTR_W-1:IDX_W], commit_idx_q[IDX_W-1:0]}] <=
				page_buf[commit_idx_q[IDX_W-1:0]];
	end

	////////////////////////////////////////////////////////////////////////
	// open-drain data drive

	logic sda_oe_q;

	// launched a core cycle after the clock fall, well inside the low phase
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			sda_oe_q <= 1'b0;
		else if (state_q == ST_ACK)
			sda_oe_q <= ack_q;
		else if (state_q == ST_TX)
			sda_oe_q <= !shift_q[7];
		else
			sda_oe_q <= 1'b0;
	end

	// only ever pulls low; the pull-up makes the ones
	assign SDA_OUT = 1'b0;
	assign SDA_OE_OUT = sda_oe_q;
	assign WRITE_BUSY_OUT = busy_q;
endmodule

// *** verif/eec_client_checker.sv ***
/*
 * Concurrent checks on the client's serial data drive and write busy ports.
 * Assumes it is bound to the client and WRITE_CYCLES matches that instance.
 */
module eec_client_checker #(
	parameter int WRITE_CYCLES = 200
) (
	input wire logic CORE_CLK_IN,
	input wire logic RESET_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_OUT,
	input wire logic WRITE_BUSY_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	// busy length counted here, too long for a repetition
	int busy_cnt_q;
	always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			busy_cnt_q <= 0;
		end else begin
			busy_cnt_q <= WRITE_BUSY_OUT ? busy_cnt_q + 1 : 0;
		end
	end
	////////////////////////////////////////
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RESET_IN);
	open_drain_a: assert property (SDA_OE_OUT |-> !SDA_OUT)
		else $error("data driven high");
	oe_slot_a: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN)
		else $error("data moved while clock high");
	oe_rise_a: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN && $past(SCL_IN, 8))
		else $error("drive not after a clock fall");
	oe_hold_a: assert property ($rose(SDA_OE_OUT) |-> SDA_OE_OUT[*6])
		else $error("drive too short");
	oe_drop_a: assert property ($fell(SDA_OE_OUT) |-> !SCL_IN && $past(SCL_IN, 8))
		else $error("release not after a clock fall");
	busy_quiet_a: assert property (WRITE_BUSY_OUT |-> !SDA_OE_OUT)
		else $error("drive during write cycle");
	busy_cause_a: assert property ($rose(WRITE_BUSY_OUT) |-> SCL_IN && SDA_IN)
		else $error("write cycle without stop");
	busy_len_a: assert property ($fell(WRITE_BUSY_OUT) |-> busy_cnt_q == WRITE_CYCLES)
		else $error("write cycle length wrong");
	busy_max_a: assert property (busy_cnt_q <= WRITE_CYCLES)
		else $error("write cycle too long");
endmodule

// *** verif/eec_host_model.sv ***
/*
 * Host side of the two-wire bus: Start, Stop, bytes out and bytes in.
 * Assumes the data wire is resolved outside with a pull-up.
 */
module eec_host_model (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	////////////////////////////////////////
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// data moves two cycles after the fall so no false condition is seen
	task automatic low(input logic b);
		scl_out = 1'b0;
		wait_cyc(2);
		sda_out = b;
		wait_cyc(6);
		scl_out = 1'b1;
		wait_cyc(8);
	endtask
	task automatic start();
		low(1'b1);
		sda_out = 1'b0;
		wait_cyc(8);
	endtask
	task automatic stop();
		low(1'b0);
		sda_out = 1'b1;
		wait_cyc(8);
	endtask
	task automatic xfer_bit(input logic b, output logic r);
		low(b);
		r = sda_in;
	endtask
	task automatic byte_tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], r);
		end
		xfer_bit(1'b1, ack);
	endtask
	task automatic byte_rx(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b1, r);
			d[i] = r;
		end
		xfer_bit(ack, r);
	endtask
endmodule

// *** verif/test_eec_client.sv ***
/*
 * Self-checking bench for the EEPROM client: selection, writes, reads, busy.
 * Assumes the host model on the bus and the checker bound to the client.
 */
module test_eec_client;
	timeunit 1ns;
	timeprecision 1ns;
	import eec_pkg::*;
	// short write cycle, still long enough to poll once inside it
	localparam int WCYC = 400;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic wp = 1'b0;
	logic slow = 1'b0;
	logic [2:0] cs = 3'h5;
	logic scl, hsda, sda_o, sda_oe, busy;
	wire sda = hsda & ~sda_oe;
	int bad_count = 0;
	int samples_checked = 0;
	always #20 core_clk = ~core_clk;
	eec_client #(.DEVICE_CODE(4'h5), .WRITE_CYCLES(WCYC)) dut (
		.CORE_CLK_IN(core_clk), .RESET_IN(reset), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .CHIP_SELECT_PIN_LOW_IN(cs[0]),
		.CHIP_SELECT_PIN_MID_IN(cs[1]), .CHIP_SELECT_PIN_HIGH_IN(cs[2]),
		.WRITE_PROTECT_IN(wp), .SUPPLY_LOW_IN(slow), .WRITE_BUSY_OUT(busy));
	eec_host_model host (.clk_in(core_clk), .sda_in(sda), .scl_out(scl), .sda_out(hsda));
	////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] d, input logic nak);
		logic a;
		host.byte_tx(d, a);
		check("ack", {7'h0, a}, {7'h0, nak});
	endtask
	task automatic wait_idle();
		for (int n = 0; n < WCYC + 50 && busy !== 1'b0; n++) begin
			@(negedge core_clk);
		end
		if (busy !== 1'b0) begin
			bad_count++;
			test_done();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
		logic [7:0] d;
		host.start();
		wr(8'h5a, 1'b0);
		wr(a, 1'b0);
		host.start();
		wr(8'h5b, 1'b0);
		host.byte_rx(1'b0, d);
		check("rd0", d, e0);
		host.byte_rx(1'b1, d);
		check("rd1", d, e1);
		check("release", {7'h0, sda_oe}, 8'h0);
		host.stop();
	endtask
	task automatic s_select();
		logic [7:0] bad [3] = '{8'h58, 8'h5e, 8'h4a};
		foreach (bad[i]) begin
			host.start();
			wr(bad[i], 1'b1);
			host.stop();
		end
		// package without the highest strap: that bit goes out as zero
		cs = 3'h3;
		host.start();
		wr(8'h56, 1'b0);
		host.stop();
		cs = 3'h5;
	endtask
	// 18 bytes from 3e wrap in the page and overwrite the first two
	task automatic s_page_write();
		host.start();
		wr(8'h5a, 1'b0);
		wr(8'h3e, 1'b0);
		for (int k = 0; k < 18; k++) begin
			wr(8'(k), 1'b0);
		end
		host.stop();
		check("busy", {7'h0, busy}, 8'h1);
		host.start();
		wr(8'h5a, 1'b1);
		host.stop();
		wait_idle();
		rd(8'h3e, 8'h10, 8'h11);
		rd(8'h30, 8'h02, 8'h03);
	endtask
	task automatic s_current_read();
		logic [7:0] d;
		host.start();
		wr(8'h5b, 1'b0);
		host.byte_rx(1'b1, d);
		check("cur", d, 8'h04);
		host.stop();
	endtask
	task automatic s_protect();
		for (int j = 0; j < 2; j++) begin
			wp = (j == 0);
			slow = (j == 1);
			host.start();
			wr(8'h5a, 1'b0);
			wr(8'h31, 1'b0);
			wr(8'haa, 1'b0);
			host.stop();
			wait_idle();
			wp = 1'b0;
			slow = 1'b0;
			rd(8'h31, 8'h03, 8'h04);
		end
	endtask
	// conditions in mid-byte must resynchronise; bytes without a Start are ignored
	task automatic s_abort();
		logic r;
		host.start();
		for (int i = 0; i < 3; i++) begin
			host.xfer_bit(1'b0, r);
		end
		host.start();
		wr(8'h5a, 1'b0);
		host.stop();
		host.start();
		host.xfer_bit(1'b0, r);
		host.xfer_bit(1'b1, r);
		host.stop();
		host.byte_tx(8'h5a, r);
		check("no start", {7'h0, r}, 8'h01);
		host.stop();
	endtask
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		host.start();
		wr(8'h5a, 1'b0);
		wr(a, 1'b0);
		wr(d, 1'b0);
		host.stop();
		wait_idle();
	endtask
	// a sequential read runs from the top address round to zero
	task automatic s_wrap();
		put(8'hff, 8'h5c);
		put(8'h00, 8'ha3);
		rd(8'hff, 8'h5c, 8'ha3);
	endtask
	initial begin
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		repeat (8) @(negedge core_clk);
		s_select();
		s_abort();
		s_page_write();
		s_current_read();
		s_protect();
		s_wrap();
		test_done();
	end
endmodule

bind eec_client eec_client_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
	.CORE_CLK_IN(CORE_CLK_IN), .RESET_IN(RESET_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
	.SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .WRITE_BUSY_OUT(WRITE_BUSY_OUT));
